// >>> logic/tmmc_pkg.sv
// Constants, register map and state encoding of the tracker mode and motion controller.
// Functional notes
// R1: After power-on enter command or tracking mode per stored start setting; factory picks command.
// R2: Track command enters tracking; escape sequence in tracking returns to command mode.
// R3: Keep user profiles 0 and 1; profile-write stores active set any time.
// R4: Factory profile is constant; both user profiles start with factory contents.
// R5: At power-on load designated user profile, default 0, designation command may pick 1.
// R6: Factory-load soft reset loads factory set; power reset reloads designated profile.
// R7: Recall command loads chosen user profile; power reset reloads designated profile.
// R8: Callable on: reports every interval up to seven days, radio kept on between.
// R9: Any of four inputs' chosen edge starts immediate report, then normal tracking resumes.
// R10: Callable on: motion sensor input fully disregarded.
// R11: Same-place skipping drops scheduled report when position stayed inside radius.
// R12: Callable off: power down between reports and ignore all commands, escape too.
// R13: Callable off: escape honoured only while acquiring fix or transmitting.
// R14: Callable off: remote profile update applied only at next wake.
// R15: Motion period split in one-minute blocks; block valid with sensitivity closures.
// R16: Motion report only after all blocks valid; invalid block restarts qualification.
// R17: After motion report, ignore motion for wait minutes; other inputs stay active.
// R18: Sensor chatters while moving, rests closed; count closures from its level.
// R19: Hybrid: non-callable while still; qualified motion switches to moving, callable.
// R20: Hybrid moving: qualifier runs; no qualification within calm minutes returns to still.
// R21: Emergency tracking ignores escape and completes a send attempt before normal tracking.
// R22: Synchronise sensor and count one closure per open-to-closed transition.
package tmmc_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_POLICY = 8'h04;
  localparam logic [7:0] A_IVAL   = 8'h08;
  localparam logic [7:0] A_MOTION = 8'h0c;
  localparam logic [7:0] A_TRIG   = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  // ==========================================================================
  // Command codes in bits [2:0] of A_CMD, argument in bit 3
  localparam logic [2:0] C_TRACK   = 3'h1;
  localparam logic [2:0] C_ESCAPE  = 3'h2;
  localparam logic [2:0] C_PWRITE  = 3'h3;
  localparam logic [2:0] C_DESIG   = 3'h4;
  localparam logic [2:0] C_FACTORY = 3'h5;
  localparam logic [2:0] C_RECALL  = 3'h6;
  localparam logic [2:0] C_START   = 3'h7;
  localparam int         CMD_ARG   = 3;
  // ==========================================================================
  // Policy register fields
  localparam logic [1:0] POL_CALL   = 2'h0;
  localparam logic [1:0] POL_NOCALL = 2'h1;
  localparam logic [1:0] POL_HYB    = 2'h2;
  localparam int         P_SKIP     = 2;
  localparam int         P_AWAKE    = 3;
  // ==========================================================================
  // Parameter set: interval in seconds, motion word {calm, wait, minutes, sens}
  localparam int          IVAL_W    = 20;
  localparam logic [19:0] FAC_IVAL  = 20'h00e10;
  localparam logic [31:0] FAC_MOT   = 32'h05050305;
  localparam int          MAX_IVAL_S = 7 * 24 * 3600;
  // ==========================================================================
  // Timing
  localparam int          CLK_MHZ     = 125;
  localparam int          SECOND_US   = 1000000;
  localparam int          CYC_PER_SEC = SECOND_US * CLK_MHZ;
  localparam logic [5:0]  MINUTE_S    = 6'h3c;
  // ==========================================================================
  // Controller states
  typedef enum logic [4:0] {
    ST_BOOT = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_IDLE = 5'b00100,
    ST_ACQ  = 5'b01000,
    ST_SEND = 5'b10000
  } tmmc_state_t;
endpackage

// >>> logic/tmmc_motion_qual.sv
// Motion qualifier: counts sensor closures per one-minute block.
`timescale 1ns/1ps
`default_nettype none
module tmmc_motion_qual
  import tmmc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             enable,
  input  wire logic             min_tick,
  input  wire logic [CNT_W-1:0] sens,
  input  wire logic [7:0]       minutes,
  // Sensor level, high means contact closed
  input  wire logic             sense,
  // Result
  output logic                  qualified
);
  logic             s1;
  logic             s2;
  logic             s3;
  logic [CNT_W-1:0] cnt;
  logic [7:0]       blk;
  logic             closure;
  logic             valid;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end
    else
    begin
      s1 <= sense;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign closure = s2 & ~s3; // [R18] [R22]
  assign valid   = (cnt >= sens);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt       <= '0;
      blk       <= 8'h00;
      qualified <= 1'b0;
    end
    else if (!enable)
    begin
      cnt       <= '0;
      blk       <= 8'h00;
      qualified <= 1'b0;
    end
    else
    begin
      qualified <= 1'b0;
      if (min_tick)
      begin
        cnt <= '0; // [R15]
        if (!valid)
          blk <= 8'h00; // [R16]
        else if (blk + 8'h01 >= minutes)
        begin
          blk       <= 8'h00;
          qualified <= 1'b1; // [R16]
        end
        else
          blk <= blk + 8'h01;
      end
      else if (closure && cnt != '1)
        cnt <= cnt + 1'b1; // [R22]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bad_block;
    enable && min_tick && !valid;
  endsequence

  AST_BAD_BLOCK_RESTART: assert property (s_bad_block |=> blk == 8'h00 && !qualified) // [R16]
    else $error("Invalid block did not restart qualification.");
  AST_ONE_PER_EDGE: assert property (enable && !min_tick && !closure |=> cnt == $past(cnt)) // [R22]
    else $error("Closure count moved without a closing edge.");
  AST_QUAL_AT_TICK: assert property (qualified |-> $past(min_tick) && $past(valid)) // [R15]
    else $error("Qualification outside a valid block end.");
endmodule
`default_nettype wire

// >>> logic/tmmc_ctrl.sv
// Tracker mode controller with profiles, report scheduling and motion policies.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tmmc_ctrl
  import tmmc_pkg::*;
#(
  parameter int CYC_SEC = CYC_PER_SEC
) (
  // Clock, power reset and non-volatile store clear
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        nv_clear_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Inputs and report engine
  input  wire logic [3:0]  ext_in,
  input  wire logic        motion_sense,
  input  wire logic        emerg_active,
  input  wire logic        fix_done,
  input  wire logic        pos_moved,
  input  wire logic        send_done,
  input  wire logic        send_ok,
  // Remote profile update
  input  wire logic        remote_valid,
  input  wire logic [19:0] remote_ival,
  input  wire logic [31:0] remote_mot,
  // Mode outputs
  output logic             tracking,
  output logic             fix_req,
  output logic             send_req,
  output logic             radio_on,
  output logic             sleeping
);
  tmmc_state_t       state;
  tmmc_state_t       next_state;
  logic [19:0]       prof_ival [2];
  logic [31:0]       prof_mot [2];
  logic              start_trk;
  logic              desig;
  logic [19:0]       act_ival;
  logic [31:0]       act_mot;
  logic [3:0]        policy;
  logic [7:0]        rise_en;
  logic [3:0]        ext_q;
  logic              trig_pend;
  logic              evt_rpt;
  logic              mot_rpt;
  logic              moving;
  logic [7:0]        calm_cnt;
  logic [7:0]        wait_cnt;
  logic              upd_pend;
  logic [19:0]       upd_ival;
  logic [31:0]       upd_mot;
  logic [31:0]       sec_cnt;
  logic              sec_tick;
  logic [5:0]        min_sub;
  logic              min_tick;
  logic [19:0]       ival_cnt;
  logic              acc;
  logic              wr;
  logic              cmd_wr;
  logic [2:0]        code;
  logic              arg;
  logic              callable;
  logic              asleep;
  logic              cmd_ok;
  logic              esc_ok;
  logic              trk_ok;
  logic              edge_hit;
  logic              qual;
  logic              qual_en;
  logic              wake;
  logic              skip;

  // ==========================================================================
  // Bus decode
  assign acc    = psel & penable & ~pready;
  assign wr     = acc & pwrite;
  assign code   = pwdata[2:0];
  assign arg    = pwdata[CMD_ARG];
  assign cmd_wr = wr && paddr == A_CMD && cmd_ok;

  assign callable = policy[1:0] == POL_CALL || (policy[1:0] == POL_HYB && moving); // [R19]
  assign asleep   = state == ST_IDLE && !callable;
  assign cmd_ok   = !asleep; // [R12]
  // Emergency tracking keeps the escape from cutting a report short.
  assign esc_ok   = cmd_wr && code == C_ESCAPE && !emerg_active // [R21]
                    && (state == ST_ACQ || state == ST_SEND || state == ST_IDLE); // [R2] [R13]
  assign trk_ok   = cmd_wr && code == C_TRACK && state == ST_CMD; // [R2]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc && paddr > A_STATUS;
      prdata  <= 32'h00000000;
      if (acc && !pwrite)
        case (paddr)
          A_POLICY: prdata <= {28'h0000000, policy};
          A_IVAL:   prdata <= {12'h000, act_ival};
          A_MOTION: prdata <= act_mot;
          A_TRIG:   prdata <= {24'h000000, rise_en};
          A_STATUS: prdata <= {16'h0000, wait_cnt[3:0], upd_pend, moving, desig, start_trk, 3'h0, state};
          default:  prdata <= 32'h00000000;
        endcase
    end
  end

  // ==========================================================================
  // Stored settings survive power resets; only the store clear restores them.
  always_ff @(posedge pclk or negedge nv_clear_n)
  begin
    if (!nv_clear_n)
    begin
      start_trk    <= 1'b0; // [R1]
      desig        <= 1'b0; // [R5]
      prof_ival[0] <= FAC_IVAL; // [R4]
      prof_ival[1] <= FAC_IVAL;
      prof_mot[0]  <= FAC_MOT;
      prof_mot[1]  <= FAC_MOT;
    end
    else if (cmd_wr)
    begin
      if (code == C_START)
        start_trk <= arg; // [R1]
      if (code == C_DESIG)
        desig <= arg; // [R5]
      if (code == C_PWRITE)
      begin
        prof_ival[arg] <= act_ival; // [R3]
        prof_mot[arg]  <= act_mot;
      end
    end
  end

  // ==========================================================================
  // Active parameter set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_ival <= FAC_IVAL;
      act_mot  <= FAC_MOT;
      policy   <= {2'b00, POL_CALL};
      rise_en  <= 8'h00;
    end
    else if (state == ST_BOOT)
    begin
      act_ival <= prof_ival[desig]; // [R5]
      act_mot  <= prof_mot[desig];
    end
    else if (upd_pend && next_state == ST_ACQ && state == ST_IDLE)
    begin
      act_ival <= upd_ival; // [R14]
      act_mot  <= upd_mot;
    end
    else if (remote_valid && callable)
    begin
      act_ival <= remote_ival;
      act_mot  <= remote_mot;
    end
    else if (cmd_wr && code == C_FACTORY)
    begin
      act_ival <= FAC_IVAL; // [R6]
      act_mot  <= FAC_MOT;
    end
    else if (cmd_wr && code == C_RECALL)
    begin
      act_ival <= prof_ival[arg]; // [R7]
      act_mot  <= prof_mot[arg];
    end
    else if (wr && cmd_ok)
      case (paddr)
        A_POLICY: policy <= pwdata[3:0];
        A_IVAL:   act_ival <= pwdata[19:0];
        A_MOTION: act_mot <= pwdata;
        A_TRIG:   rise_en <= pwdata[7:0];
        default:  ;
      endcase
  end

  // A remote update that arrives while asleep waits for the next wake.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upd_pend <= 1'b0;
      upd_ival <= FAC_IVAL;
      upd_mot  <= FAC_MOT;
    end
    else if (remote_valid && !callable)
    begin
      upd_pend <= 1'b1; // [R14]
      upd_ival <= remote_ival;
      upd_mot  <= remote_mot;
    end
    else if (state == ST_IDLE && next_state == ST_ACQ)
      upd_pend <= 1'b0;
  end

  // ==========================================================================
  // Second and minute ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_cnt  <= 32'h00000000;
      sec_tick <= 1'b0;
      min_sub  <= 6'h00;
      min_tick <= 1'b0;
    end
    else
    begin
      sec_tick <= sec_cnt == 32'(CYC_SEC - 1);
      sec_cnt  <= (sec_cnt == 32'(CYC_SEC - 1)) ? 32'h00000000 : sec_cnt + 32'h00000001;
      min_tick <= sec_tick && min_sub == MINUTE_S - 6'h01;
      if (sec_tick)
        min_sub <= (min_sub == MINUTE_S - 6'h01) ? 6'h00 : min_sub + 6'h01;
    end
  end

  // Interval 0 gives back-to-back reports.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ival_cnt <= 20'h00000;
    else if (state != ST_IDLE)
      ival_cnt <= 20'h00000;
    else if (sec_tick && ival_cnt < act_ival)
      ival_cnt <= ival_cnt + 20'h00001; // [R8]
  end

  // ==========================================================================
  // Edge triggers on the four inputs
  assign edge_hit = |((rise_en[3:0] & ext_in & ~ext_q) | (rise_en[7:4] & ~ext_in & ext_q)); // [R9]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_q     <= 4'hf;
      trig_pend <= 1'b0;
    end
    else
    begin
      ext_q <= ext_in;
      // An edge seen in IDLE wakes the controller at once, so only edges during a report are queued.
      if (edge_hit && (state == ST_ACQ || state == ST_SEND))
        trig_pend <= 1'b1; // [R9]
      else if (state == ST_IDLE && next_state == ST_ACQ)
        trig_pend <= 1'b0;
    end
  end

  // ==========================================================================
  // Motion policies
  assign qual_en = (state != ST_CMD && state != ST_BOOT) && (policy[1:0] == POL_HYB // [R20]
                   || (policy[1:0] == POL_NOCALL && policy[P_AWAKE] && wait_cnt == 8'h00)); // [R10] [R17]

  tmmc_motion_qual u_qual (
    .clk       (pclk),
    .rst_n     (presetn),
    .enable    (qual_en),
    .min_tick  (min_tick),
    .sens      (act_mot[7:0]),
    .minutes   (act_mot[15:8]),
    .sense     (motion_sense),
    .qualified (qual)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      moving   <= 1'b0;
      calm_cnt <= 8'h00;
      wait_cnt <= 8'h00;
    end
    else
    begin
      if (policy[1:0] != POL_HYB)
        moving <= 1'b0;
      else if (qual)
      begin
        moving   <= 1'b1; // [R19]
        calm_cnt <= 8'h00;
      end
      else if (moving && min_tick)
      begin
        if (calm_cnt + 8'h01 >= act_mot[31:24])
          moving <= 1'b0; // [R20]
        calm_cnt <= calm_cnt + 8'h01;
      end
      if (state == ST_SEND && send_done && send_ok && mot_rpt)
        wait_cnt <= act_mot[23:16]; // [R17]
      else if (min_tick && wait_cnt != 8'h00)
        wait_cnt <= wait_cnt - 8'h01;
    end
  end

  // ==========================================================================
  // Mode sequencing
  assign wake = ival_cnt >= act_ival || trig_pend || edge_hit
                || (qual && policy[1:0] == POL_NOCALL);
  assign skip = policy[P_SKIP] && !pos_moved && !evt_rpt; // [R11]

  always_comb
  begin
    next_state = state;
    case (state)
      ST_BOOT: next_state = start_trk ? ST_IDLE : ST_CMD; // [R1]
      ST_CMD:  if (trk_ok) next_state = ST_IDLE; // [R2]
      ST_IDLE:
        if (esc_ok && callable) next_state = ST_CMD; // [R12]
        else if (wake) next_state = ST_ACQ; // [R8] [R9]
      ST_ACQ:
        if (esc_ok) next_state = ST_CMD; // [R13]
        else if (fix_done) next_state = skip ? ST_IDLE : ST_SEND; // [R11]
      ST_SEND:
        if (esc_ok) next_state = ST_CMD;
        else if (send_done) next_state = ST_IDLE; // [R9] [R21]
      default: next_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state   <= ST_BOOT;
      evt_rpt <= 1'b0;
      mot_rpt <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_ACQ)
      begin
        evt_rpt <= trig_pend || edge_hit || qual;
        mot_rpt <= qual && ival_cnt < act_ival && !trig_pend && !edge_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tracking <= 1'b0;
      fix_req  <= 1'b0;
      send_req <= 1'b0;
      radio_on <= 1'b0;
      sleeping <= 1'b0;
    end
    else
    begin
      tracking <= next_state == ST_IDLE || next_state == ST_ACQ || next_state == ST_SEND;
      fix_req  <= next_state == ST_ACQ;
      send_req <= next_state == ST_SEND;
      radio_on <= !(next_state == ST_IDLE && !callable); // [R8] [R12]
      sleeping <= next_state == ST_IDLE && !callable; // [R12]
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_motion_sent;
    state == ST_SEND && send_done && send_ok && mot_rpt && act_mot[23:16] != 8'h00;
  endsequence

  AST_BOOT_MODE: assert property (state == ST_BOOT |=> state == ($past(start_trk) ? ST_IDLE : ST_CMD)) // [R1]
    else $error("Wrong start-up mode.");
  AST_BOOT_LOAD: assert property (state == ST_BOOT |=> act_ival == $past(prof_ival[desig])) // [R5]
    else $error("Designated profile not loaded at start.");
  AST_TRACK: assert property (trk_ok |=> state == ST_IDLE ##1 tracking) // [R2]
    else $error("Track command did not enter tracking.");
  AST_FACTORY: assert property (cmd_wr && code == C_FACTORY && state != ST_BOOT && !remote_valid && !upd_pend
                               |=> act_ival == FAC_IVAL) // [R6]
    else $error("Factory load did not restore the factory set.");
  AST_ASLEEP_DEAF: assert property (asleep |=> state != ST_CMD) // [R12]
    else $error("Command honoured while powered down.");
  AST_EMERG_ESC: assert property (emerg_active && state == ST_SEND && !send_done |=> state == ST_SEND) // [R21]
    else $error("Escape honoured during emergency tracking.");
  AST_CALL_NO_MOTION: assert property (policy[1:0] == POL_CALL |-> !qual_en) // [R10]
    else $error("Motion qualifier running with callable on.");
  AST_MOTION_WAIT: assert property (s_motion_sent |=> !qual_en [*2]) // [R17]
    else $error("Motion input observed during the wait period.");
endmodule
`default_nettype wire

// >>> bench/tmmc_report_model.sv
// Behavioural model of the report engine that answers fix and send requests.
`timescale 1ns/1ps
`default_nettype none
module tmmc_report_model (
  // Clock
  input  wire logic pclk,
  // Requests and pace
  input  wire logic fix_req,
  input  wire logic send_req,
  input  wire logic slow,
  input  wire logic moved,
  // Answers
  output logic      fix_done,
  output logic      send_done,
  output wire logic send_ok,
  output wire logic pos_moved
);
  int fcnt;
  int scnt;
  // Every send succeeds; whether the fix has moved is chosen by the bench.
  assign send_ok   = 1'b1;
  assign pos_moved = moved;
  initial
  begin
    fix_done  = 1'b0;
    send_done = 1'b0;
    fcnt      = 0;
    scnt      = 0;
  end
  // ==========================================================================
  // Answers are one-cycle pulses, given only while the request stands.
  always @(posedge pclk)
  begin
    fix_done <= 1'b0;
    if (fix_req && !fix_done)
    begin
      fcnt <= (fcnt >= (slow ? 200 : 3)) ? 0 : fcnt + 1;
      if (fcnt >= (slow ? 200 : 3))
        fix_done <= 1'b1;
    end
    else
      fcnt <= 0;
  end
  always @(posedge pclk)
  begin
    send_done <= 1'b0;
    if (send_req && !send_done)
    begin
      scnt <= (scnt >= 4) ? 0 : scnt + 1;
      if (scnt >= 4)
        send_done <= 1'b1;
    end
    else
      scnt <= 0;
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench of the tracker mode controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import tmmc_pkg::*;
  logic        pclk, presetn, nv_clear_n, psel, penable, pwrite, err;
  logic        emerg_active, motion_sense, remote_valid, slow, chatter, moved;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  ext_in;
  logic        pready, pslverr, fix_done, send_done, send_ok, pos_moved;
  logic        tracking, fix_req, send_req, radio_on, sleeping;
  int          n_errors, checks_done, ccnt;
  bit          hit;
  tmmc_ctrl #(.CYC_SEC(10)) dut_u (.pclk(pclk), .presetn(presetn), .nv_clear_n(nv_clear_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_in(ext_in), .motion_sense(motion_sense), .emerg_active(emerg_active),
    .fix_done(fix_done), .pos_moved(pos_moved), .send_done(send_done), .send_ok(send_ok),
    .remote_valid(remote_valid), .remote_ival(20'h00777), .remote_mot(32'h05050305), .tracking(tracking),
    .fix_req(fix_req), .send_req(send_req), .radio_on(radio_on), .sleeping(sleeping));
  tmmc_report_model model_u (.pclk(pclk), .fix_req(fix_req), .send_req(send_req), .slow(slow), .moved(moved),
    .fix_done(fix_done), .send_done(send_done), .send_ok(send_ok), .pos_moved(pos_moved));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // A moving sensor chatters; a still one rests closed.
  always @(posedge pclk)
  begin
    ccnt <= ccnt + 1;
    if (!chatter)
      motion_sense <= 1'b1;
    else if (ccnt[3:0] == 4'h0)
      motion_sense <= ~motion_sense;
  end
  // ==========================================================================
  // Tasks
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task do_reset(input logic nv);
  begin
    presetn    <= 1'b0;
    nv_clear_n <= ~nv;
    repeat (16) @(posedge pclk);
    presetn    <= 1'b1;
    nv_clear_n <= 1'b1;
  end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
  begin
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rdv     = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      stop_test();
    end
  end
  endtask
  // Sel 0 waits for a fix request, sel 1 for the end of a report, sel 2 for a send request.
  task wait_ev(input int sel, input int lim);
  begin
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(posedge pclk);
      hit = (sel == 0) ? (fix_req === 1'b1) : (sel == 2) ? (send_req === 1'b1)
            : (fix_req === 1'b0 && send_req === 1'b0);
    end
  end
  endtask
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    {presetn, nv_clear_n, psel, penable, pwrite, emerg_active, remote_valid, slow, chatter} = '0;
    {paddr, pwdata, ext_in, ccnt, n_errors, checks_done} = '0;
    motion_sense = 1'b1;
    moved = 1'b1;
    do_reset(1'b1);
    apb(0, A_STATUS, 0);
    `CHK("state", ST_CMD, rdv[4:0])
    `CHK("desig", 1'b0, rdv[9])
    apb(0, A_IVAL, 0);
    `CHK("ival", FAC_IVAL, rdv[19:0])
    apb(0, A_MOTION, 0);
    `CHK("motion", FAC_MOT, rdv)
    apb(0, 8'h18, 0);
    `CHK("slverr", 1'b1, err)
    $display("test reset done");
    apb(1, A_IVAL, 32'h00000123);
    apb(1, A_CMD, 32'h0000000b);
    apb(1, A_CMD, 32'h00000005);
    apb(0, A_IVAL, 0);
    `CHK("ival", FAC_IVAL, rdv[19:0])
    apb(1, A_CMD, 32'h0000000e);
    apb(0, A_IVAL, 0);
    `CHK("ival", 20'h00123, rdv[19:0])
    apb(1, A_CMD, 32'h00000006);
    apb(0, A_IVAL, 0);
    `CHK("ival", FAC_IVAL, rdv[19:0])
    apb(1, A_CMD, 32'h0000000c);
    apb(1, A_CMD, 32'h00000005);
    do_reset(1'b0);
    apb(0, A_IVAL, 0);
    `CHK("ival", 20'h00123, rdv[19:0])
    $display("test profiles done");
    apb(1, A_CMD, 32'h0000000f);
    do_reset(1'b0);
    apb(0, A_STATUS, 0);
    `CHK("state", ST_IDLE, rdv[4:0])
    apb(1, A_CMD, 32'h00000002);
    apb(0, A_STATUS, 0);
    `CHK("state", ST_CMD, rdv[4:0])
    $display("test start done");
    apb(1, A_IVAL, 32'h00000e10);
    apb(1, A_TRIG, 32'h00000001);
    apb(1, A_CMD, 32'h00000001);
    `CHK("radio", 1'b1, radio_on)
    ext_in[0] <= 1'b1;
    wait_ev(0, 10);
    `CHK("edge fix", 1'b1, hit)
    wait_ev(1, 100);
    `CHK("report end", 1'b1, hit)
    `CHK("tracking", 1'b1, tracking)
    moved <= 1'b0;
    apb(1, A_POLICY, 32'h00000004);
    apb(1, A_IVAL, 32'h00000003);
    wait_ev(0, 100);
    `CHK("ival fix", 1'b1, hit)
    wait_ev(2, 100);
    `CHK("skip send", 1'b0, hit)
    moved <= 1'b1;
    apb(1, A_IVAL, 32'h00000e10);
    wait_ev(1, 100);
    `CHK("report end", 1'b1, hit)
    apb(1, A_POLICY, 32'h00000008);
    chatter <= 1'b1;
    wait_ev(0, 1500);
    `CHK("motion fix", 1'b0, hit)
    $display("test callable done");
    chatter   <= 1'b0;
    ext_in[0] <= 1'b0;
    apb(1, A_POLICY, 32'h00000001);
    repeat (3) @(posedge pclk);
    `CHK("sleep", 1'b1, sleeping)
    apb(1, A_CMD, 32'h00000002);
    apb(0, A_STATUS, 0);
    `CHK("state", ST_IDLE, rdv[4:0])
    @(posedge pclk);
    remote_valid <= 1'b1;
    @(posedge pclk);
    remote_valid <= 1'b0;
    apb(0, A_IVAL, 0);
    `CHK("ival", 20'h00e10, rdv[19:0])
    slow      <= 1'b1;
    ext_in[0] <= 1'b1;
    wait_ev(0, 20);
    `CHK("edge fix", 1'b1, hit)
    apb(0, A_IVAL, 0);
    `CHK("ival", 20'h00777, rdv[19:0])
    emerg_active <= 1'b1;
    apb(1, A_CMD, 32'h00000002);
    apb(0, A_STATUS, 0);
    `CHK("state", ST_ACQ, rdv[4:0])
    emerg_active <= 1'b0;
    apb(1, A_CMD, 32'h00000002);
    apb(0, A_STATUS, 0);
    `CHK("state", ST_CMD, rdv[4:0])
    slow <= 1'b0;
    $display("test low power done");
    apb(1, A_MOTION, 32'h00020102);
    apb(1, A_POLICY, 32'h00000009);
    apb(1, A_CMD, 32'h00000001);
    chatter <= 1'b1;
    wait_ev(0, 1500);
    `CHK("motion fix", 1'b1, hit)
    wait_ev(1, 100);
    `CHK("report end", 1'b1, hit)
    apb(0, A_STATUS, 0);
    `CHK("wait", 4'h2, rdv[15:12])
    chatter <= 1'b0;
    $display("test motion done");
    stop_test();
  end
endmodule
`default_nettype wire
